// *** pkg/usb_fifo_window_pkg.sv ***
// Package with register map, field layouts and carrier types for the USB FIFO window block.
package usb_fifo_window_pkg;

	localparam logic [7:0] OFS_BYTE_COUNT  = 8'hF2;
	localparam logic [7:0] OFS_BASE_HIGH   = 8'hF3;
	localparam logic [7:0] OFS_BASE_LOW    = 8'hF4;
	localparam logic [7:0] OFS_SETUP_INDEX = 8'hF5;
	localparam logic [7:0] OFS_SETUP_VALUE = 8'hF6;
	localparam logic [7:0] OFS_FIFO_SELECT = 8'hF7;
	localparam logic [7:0] OFS_FIFO_STATUS = 8'hF8;

	localparam int         NUM_ENDPOINTS   = 10;
	localparam int         FIFO_DEPTH      = 64;
	localparam int         SETUP_BYTES     = 8;
	localparam logic [6:0] MAX_BYTE_COUNT  = 7'h40;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam int         BASE_LOW_LSB    = 6;
	localparam int         SEL_EP_MSB      = 3;
	localparam int         SEL_DIR_BIT     = 7;
	localparam int         STATUS_BUSY_BIT = 0;

	// Request from the serial engine toward the CPU-side logic.
	typedef struct packed {
		logic       rx_wr;
		logic [5:0] rx_addr;
		logic [7:0] rx_data;
		logic [3:0] rx_ep;
		logic       rx_done;
		logic [6:0] rx_count;
		logic       setup_wr;
		logic [2:0] setup_idx;
		logic [7:0] setup_data;
		logic       tx_rd;
		logic [3:0] tx_ep;
		logic [5:0] tx_addr;
		logic       tx_done;
	} engine_req_t;

	// Answer toward the serial engine.
	typedef struct packed {
		logic [7:0] tx_data;
		logic       tx_ready;
		logic [6:0] tx_count;
	} engine_rsp_t;

endpackage : usb_fifo_window_pkg

// *** design/usb_fifo_window_setup_access.sv ***
// CPU-side FIFO window, byte count and setup buffer access logic of a USB function.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_window_setup_access #(
	parameter int NUM_EP = usb_fifo_window_pkg::NUM_ENDPOINTS,
	parameter int DEPTH  = usb_fifo_window_pkg::FIFO_DEPTH
) (
	input  wire logic                              clk_i,
	input  wire logic                              srst_i,
	input  wire logic [7:0]                        avs_address_i,
	input  wire logic                              avs_read_i,
	input  wire logic                              avs_write_i,
	input  wire logic [7:0]                        avs_writedata_i,
	output logic      [7:0]                        avs_readdata_o,
	output logic                                   avs_waitrequest_o,
	input  wire logic [15:0]                       xd_address_i,
	input  wire logic                              xd_read_i,
	input  wire logic                              xd_write_i,
	input  wire logic [7:0]                        xd_writedata_i,
	output logic      [7:0]                        xd_readdata_o,
	output logic                                   xd_hit_o,
	input  wire usb_fifo_window_pkg::engine_req_t  eng_req_i,
	output usb_fifo_window_pkg::engine_rsp_t       eng_rsp_o
);

	localparam int EW = $clog2(NUM_EP);
	localparam int AW = $clog2(DEPTH);

	// Index 0 to NUM_EP-1 are OUT FIFOs, NUM_EP upward are IN FIFOs.
	logic [7:0] fifo_mem [2*NUM_EP*DEPTH];
	logic [7:0] setup_mem [usb_fifo_window_pkg::SETUP_BYTES];

	// Byte counts and busy flags, one set per endpoint.
	logic [6:0]        in_count_q  [NUM_EP];
	logic [6:0]        in_count_d  [NUM_EP];
	logic [6:0]        out_count_q [NUM_EP];
	logic [6:0]        out_count_d [NUM_EP];
	logic [NUM_EP-1:0] busy_q;
	logic [NUM_EP-1:0] busy_d;
	// Window base, setup index and endpoint select, all written over the register bus.
	logic [7:0]        base_high_q;
	logic [7:0]        base_high_d;
	logic [1:0]        base_low_q;
	logic [1:0]        base_low_d;
	logic [2:0]        setup_idx_q;
	logic [2:0]        setup_idx_d;
	logic [3:0]        sel_ep_q;
	logic [3:0]        sel_ep_d;
	logic              sel_in_q;
	logic              sel_in_d;
	// Registered answers toward the bus, the window and the engine.
	logic [7:0]        rdata_q;
	logic [7:0]        rdata_d;
	logic              ack_q;
	logic              ack_d;
	logic [7:0]        xd_rdata_q;
	logic [7:0]        xd_rdata_d;
	logic              xd_hit_q;
	logic              xd_hit_d;
	logic [7:0]        tx_data_q;
	logic [7:0]        tx_data_d;
	logic              tx_ready_q;
	logic              tx_ready_d;
	logic [6:0]        tx_count_q;
	logic [6:0]        tx_count_d;

	logic              bus_req;
	logic              cpu_wr;
	logic              cpu_rd;
	logic              win_hit;
	logic [EW:0]       win_fifo;
	logic [6:0]        wr_count;
	logic [EW-1:0]     sel_idx;
	logic [EW-1:0]     tx_idx;
	logic [EW-1:0]     rx_idx;

	assign sel_idx  = sel_ep_q[EW-1:0];
	assign tx_idx   = eng_req_i.tx_ep[EW-1:0];
	assign rx_idx   = eng_req_i.rx_ep[EW-1:0];
	// The slave answers one cycle after a request appears; waitrequest drops with the answer.
	assign bus_req  = (avs_read_i || avs_write_i) && !ack_q;
	// A write lands only at the edge at which the master sees waitrequest low, never before.
	assign cpu_wr   = avs_write_i && ack_q;
	assign cpu_rd   = avs_read_i && bus_req;
	assign win_hit  = (xd_address_i[15:8] == base_high_q) && (xd_address_i[7:6] == base_low_q);
	assign win_fifo = sel_in_q ? (EW+1)'(NUM_EP) + (EW+1)'(sel_idx) : (EW+1)'(sel_idx);
	// Counts above a full FIFO are clipped so the engine can never send past the end.
	assign wr_count = (avs_writedata_i[6:0] > usb_fifo_window_pkg::MAX_BYTE_COUNT)
		? usb_fifo_window_pkg::MAX_BYTE_COUNT : avs_writedata_i[6:0];

	always_comb
	begin
		base_high_d = base_high_q;
		base_low_d  = base_low_q;
		setup_idx_d = setup_idx_q;
		sel_ep_d    = sel_ep_q;
		sel_in_d    = sel_in_q;
		in_count_d  = in_count_q;
		out_count_d = out_count_q;
		busy_d      = busy_q;
		ack_d       = bus_req;
		rdata_d     = 8'h00;
		if (eng_req_i.tx_done && (32'(eng_req_i.tx_ep) < NUM_EP))
		begin
			busy_d[tx_idx] = 1'b0;
		end
		if (eng_req_i.rx_done && (32'(eng_req_i.rx_ep) < NUM_EP))
		begin
			out_count_d[rx_idx] = eng_req_i.rx_count;
		end
		// The arming write comes after the engine's clear, so arming wins when both fall in one cycle.
		if (cpu_wr)
		begin
			unique case (avs_address_i)
				usb_fifo_window_pkg::OFS_BYTE_COUNT:
				begin
					if (sel_in_q && (32'(sel_ep_q) < NUM_EP))
					begin
						in_count_d[sel_idx] = wr_count;
						busy_d[sel_idx]     = 1'b1;
					end
				end
				usb_fifo_window_pkg::OFS_BASE_HIGH:   base_high_d = avs_writedata_i;
				usb_fifo_window_pkg::OFS_BASE_LOW:    base_low_d  = avs_writedata_i[7:6];
				usb_fifo_window_pkg::OFS_SETUP_INDEX: setup_idx_d = avs_writedata_i[2:0];
				usb_fifo_window_pkg::OFS_FIFO_SELECT:
				begin
					sel_ep_d = avs_writedata_i[usb_fifo_window_pkg::SEL_EP_MSB:0];
					sel_in_d = avs_writedata_i[usb_fifo_window_pkg::SEL_DIR_BIT];
				end
				default: ;
			endcase
		end
		// Reserved bits and unmapped offsets read as zero.
		if (cpu_rd)
		begin
			unique case (avs_address_i)
				usb_fifo_window_pkg::OFS_BYTE_COUNT:
					rdata_d = {1'b0, sel_in_q ? in_count_q[sel_idx] : out_count_q[sel_idx]};
				usb_fifo_window_pkg::OFS_BASE_HIGH:   rdata_d = base_high_q;
				usb_fifo_window_pkg::OFS_BASE_LOW:    rdata_d = {base_low_q, 6'b00_0000};
				usb_fifo_window_pkg::OFS_SETUP_INDEX: rdata_d = {5'b0_0000, setup_idx_q};
				usb_fifo_window_pkg::OFS_SETUP_VALUE: rdata_d = setup_mem[setup_idx_q];
				usb_fifo_window_pkg::OFS_FIFO_SELECT: rdata_d = {sel_in_q, 3'b000, sel_ep_q};
				usb_fifo_window_pkg::OFS_FIFO_STATUS: rdata_d = {7'h00, busy_q[sel_idx]};
				default:                              rdata_d = 8'h00;
			endcase
		end
	end

	always_comb
	begin
		xd_hit_d   = (xd_read_i || xd_write_i) && win_hit && (32'(sel_ep_q) < NUM_EP);
		xd_rdata_d = 8'h00;
		if (xd_read_i && xd_hit_d)
		begin
			xd_rdata_d = fifo_mem[{win_fifo, xd_address_i[AW-1:0]}];
		end
	end

	// The engine sees the armed state of the endpoint that it points at, one cycle late.
	always_comb
	begin
		tx_ready_d = 1'b0;
		tx_count_d = 7'h00;
		tx_data_d  = 8'h00;
		if (32'(eng_req_i.tx_ep) < NUM_EP)
		begin
			tx_ready_d = busy_q[tx_idx];
			tx_count_d = in_count_q[tx_idx];
			if (eng_req_i.tx_rd)
			begin
				tx_data_d = fifo_mem[{(EW+1)'(NUM_EP) + (EW+1)'(tx_idx), eng_req_i.tx_addr}];
			end
		end
	end

	// The FIFO memory carries no reset; the setup buffer is cleared to REG_RESET on reset.
	always_ff @(posedge clk_i)
	begin
		if (xd_write_i && win_hit && (32'(sel_ep_q) < NUM_EP))
		begin
			fifo_mem[{win_fifo, xd_address_i[AW-1:0]}] <= xd_writedata_i;
		end
		if (eng_req_i.rx_wr && (32'(eng_req_i.rx_ep) < NUM_EP))
		begin
			fifo_mem[{(EW+1)'(rx_idx), eng_req_i.rx_addr}] <= eng_req_i.rx_data;
		end
		if (srst_i)
		begin
			for (int i = 0; i < usb_fifo_window_pkg::SETUP_BYTES; i++)
			begin
				setup_mem[i] <= usb_fifo_window_pkg::REG_RESET;
			end
		end
		else if (eng_req_i.setup_wr)
		begin
			setup_mem[eng_req_i.setup_idx] <= eng_req_i.setup_data;
		end
	end

	// Register file state.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < NUM_EP; i++)
			begin
				in_count_q[i]  <= 7'h00;
				out_count_q[i] <= 7'h00;
			end
			busy_q      <= '0;
			base_high_q <= usb_fifo_window_pkg::REG_RESET;
			base_low_q  <= 2'b00;
			setup_idx_q <= 3'b000;
			sel_ep_q    <= 4'h0;
			sel_in_q    <= 1'b0;
		end
		else
		begin
			in_count_q  <= in_count_d;
			out_count_q <= out_count_d;
			busy_q      <= busy_d;
			base_high_q <= base_high_d;
			base_low_q  <= base_low_d;
			setup_idx_q <= setup_idx_d;
			sel_ep_q    <= sel_ep_d;
			sel_in_q    <= sel_in_d;
		end
	end

	// Register bus answer.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rdata_q <= 8'h00;
			ack_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
		end
	end

	// Data-space window answer; a miss reads as zero.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			xd_rdata_q <= 8'h00;
			xd_hit_q   <= 1'b0;
		end
		else
		begin
			xd_rdata_q <= xd_rdata_d;
			xd_hit_q   <= xd_hit_d;
		end
	end

	// Serial engine answer.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			tx_data_q  <= 8'h00;
			tx_ready_q <= 1'b0;
			tx_count_q <= 7'h00;
		end
		else
		begin
			tx_data_q  <= tx_data_d;
			tx_ready_q <= tx_ready_d;
			tx_count_q <= tx_count_d;
		end
	end

	assign avs_readdata_o     = rdata_q;
	assign avs_waitrequest_o  = !ack_q;
	assign xd_readdata_o      = xd_rdata_q;
	assign xd_hit_o           = xd_hit_q;
	assign eng_rsp_o.tx_data  = tx_data_q;
	assign eng_rsp_o.tx_ready = tx_ready_q;
	assign eng_rsp_o.tx_count = tx_count_q;

endmodule : usb_fifo_window_setup_access
`default_nettype wire

// *** sim/usb_engine_model.sv ***
// Behavioural serial engine that fills OUT and setup buffers and drains IN FIFOs.
`timescale 1ns/1ps
`default_nettype none
module usb_engine_model (
	input  wire logic                             clk_i,
	input  wire usb_fifo_window_pkg::engine_rsp_t rsp_i,
	output var  usb_fifo_window_pkg::engine_req_t req_o
);
	initial req_o = '0;
	// Packets never exceed one FIFO, so n stays at or below 64.
	task automatic pkt(input logic setup, input logic [3:0] ep, input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			req_o.rx_wr <= !setup;
			req_o.setup_wr <= setup;
			req_o.rx_ep <= ep;
			req_o.rx_addr <= 6'(i);
			req_o.setup_idx <= 3'(i);
			req_o.rx_data <= b + 8'(i);
			req_o.setup_data <= b + 8'(i);
		end
		@(posedge clk_i);
		req_o.rx_wr <= 1'b0;
		req_o.setup_wr <= 1'b0;
		req_o.rx_data <= ~req_o.rx_data;
		req_o.setup_data <= ~req_o.setup_data;
		req_o.rx_done <= !setup;
		req_o.rx_count <= 7'(n);
		@(posedge clk_i);
		req_o.rx_done <= 1'b0;
	endtask : pkt
	task automatic tx(input logic [3:0] ep, input logic rd, input logic dn, input logic [5:0] a, output logic [7:0] q);
		@(posedge clk_i);
		req_o.tx_ep <= ep;
		req_o.tx_rd <= rd;
		req_o.tx_done <= dn;
		req_o.tx_addr <= a;
		@(posedge clk_i);
		req_o.tx_rd <= 1'b0;
		req_o.tx_done <= 1'b0;
		@(negedge clk_i);
		q = rsp_i.tx_data;
	endtask : tx
endmodule : usb_engine_model
`default_nettype wire

// *** sim/usb_fifo_window_monitor.sv ***
// Assertion checker for the register bus and data-space window ports.
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_window_monitor (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [7:0]  avs_writedata_i,
	input wire logic [7:0]  avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [15:0] xd_address_i,
	input wire logic        xd_read_i,
	input wire logic        xd_write_i,
	input wire logic [7:0]  xd_readdata_o,
	input wire logic        xd_hit_o
);
	logic [9:0] base_q;
	logic [9:0] base_d;
	logic       wr_ack;
	logic       rd_ack;
	assign wr_ack = avs_write_i && !avs_waitrequest_o;
	assign rd_ack = avs_read_i && !avs_waitrequest_o;
	// Shadow of the window base so window decoding can be judged.
	always_comb
	begin
		base_d = base_q;
		if (wr_ack && avs_address_i == usb_fifo_window_pkg::OFS_BASE_HIGH)
			base_d[9:2] = avs_writedata_i;
		if (wr_ack && avs_address_i == usb_fifo_window_pkg::OFS_BASE_LOW)
			base_d[1:0] = avs_writedata_i[7:6];
		if (srst_i)
			base_d = '0;
	end
	always_ff @(posedge clk_i)
		base_q <= base_d;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_rst; $past(srst_i) |-> avs_waitrequest_o && avs_readdata_o == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("bus not idle after reset");
	property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_one: assert property (p_one) else $error("ack longer than one cycle");
	property p_due; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_due: assert property (p_due) else $error("ack late");
	property p_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	property p_idle; avs_waitrequest_o |-> avs_readdata_o == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside ack");
	property p_low; rd_ack && avs_address_i == 8'hF4 |-> avs_readdata_o == {base_q[1:0], 6'h00}; endproperty
	a_low: assert property (p_low) else $error("base low readback");
	property p_high; rd_ack && avs_address_i == 8'hF3 |-> avs_readdata_o == base_q[9:2]; endproperty
	a_high: assert property (p_high) else $error("base high readback");
	property p_cnt; rd_ack && avs_address_i == 8'hF2 |-> avs_readdata_o <= 8'h40; endproperty
	a_cnt: assert property (p_cnt) else $error("count above 64");
	property p_idx; rd_ack && avs_address_i == 8'hF5 |-> avs_readdata_o[7:3] == 5'h00; endproperty
	a_idx: assert property (p_idx) else $error("index reserved bits set");
	property p_miss; (xd_read_i || xd_write_i) && xd_address_i[15:6] != base_q |=> !xd_hit_o && xd_readdata_o == 8'h00;
	endproperty
	a_miss: assert property (p_miss) else $error("hit outside window");
	c_rd: cover property (rd_ack);
	c_wr: cover property (wr_ack);
	c_hit: cover property (xd_hit_o);
endmodule : usb_fifo_window_monitor
bind usb_fifo_window_setup_access usb_fifo_window_monitor usb_fifo_window_monitor_inst (.clk_i, .srst_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
	.xd_address_i, .xd_read_i, .xd_write_i, .xd_readdata_o, .xd_hit_o);
`default_nettype wire

// *** sim/usb_fifo_window_setup_access_bench.sv ***
// Self-checking bench for the USB FIFO window and setup access block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module usb_fifo_window_setup_access_bench;
	typedef struct { logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; } row_t;
	logic                             clk_i = 1'b0;
	logic                             srst_i = 1'b1;
	logic [7:0]                       avs_address_i = 8'h00;
	logic                             avs_read_i = 1'b0;
	logic                             avs_write_i = 1'b0;
	logic [7:0]                       avs_writedata_i = 8'h00;
	logic [7:0]                       avs_readdata_o;
	logic                             avs_waitrequest_o;
	logic [15:0]                      xd_address_i = 16'h0000;
	logic                             xd_read_i = 1'b0;
	logic                             xd_write_i = 1'b0;
	logic [7:0]                       xd_writedata_i = 8'h00;
	logic [7:0]                       xd_readdata_o;
	logic                             xd_hit_o;
	usb_fifo_window_pkg::engine_req_t eng_req_i;
	usb_fifo_window_pkg::engine_rsp_t eng_rsp_o;
	int                               miscompares = 0;
	int                               check_count = 0;
	logic [7:0]                       rd;
	row_t rows [13] = '{'{8'hF2, 0, 0, 0}, '{8'hF3, 0, 0, 0}, '{8'hF4, 0, 0, 0}, '{8'hF5, 0, 0, 0},
		'{8'hF6, 0, 0, 0}, '{8'hF3, 1, 8'hA5, 8'hA5}, '{8'hF4, 1, 8'hFF, 8'hC0}, '{8'hF5, 1, 8'hFF, 8'h07},
		'{8'hF6, 1, 8'h55, 8'h00}, '{8'hF9, 1, 8'h12, 8'h00}, '{8'hF7, 1, 8'h83, 8'h83}, '{8'hF2, 1, 8'h7F, 8'h40},
		'{8'hF8, 0, 8'h00, 8'h01}};
	usb_fifo_window_setup_access usb_fifo_window_setup_access_inst (.clk_i, .srst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .xd_address_i, .xd_read_i,
		.xd_write_i, .xd_writedata_i, .xd_readdata_o, .xd_hit_o, .eng_req_i, .eng_rsp_o);
	usb_engine_model usb_engine_model_inst (.clk_i, .rsp_i(eng_rsp_o), .req_o(eng_req_i));
	always #4 clk_i = ~clk_i;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic av(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
		if (n >= 50)
			miscompares++;
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : av
	task automatic xd(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		xd_address_i <= a;
		xd_writedata_i <= d;
		xd_write_i <= w;
		xd_read_i <= !w;
		@(posedge clk_i);
		xd_write_i <= 1'b0;
		xd_read_i <= 1'b0;
		@(negedge clk_i);
	endtask : xd
	initial
	begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].w)
				av(rows[i].a, 1'b1, rows[i].d);
			av(rows[i].a, 1'b0, 8'h00);
			`CHK(rd, rows[i].e)
		end
		$display("register table done");
		usb_engine_model_inst.tx(4'h3, 1'b0, 1'b0, 6'h00, rd);
		`CHK(eng_rsp_o.tx_ready, 1'b1)
		`CHK(eng_rsp_o.tx_count, 7'h40)
		usb_engine_model_inst.tx(4'h3, 1'b0, 1'b1, 6'h00, rd);
		usb_engine_model_inst.tx(4'h3, 1'b0, 1'b0, 6'h00, rd);
		`CHK(eng_rsp_o.tx_ready, 1'b0)
		$display("arm done");
		// Firmware keeps the window in an otherwise unused region.
		av(8'hF3, 1'b1, 8'h12);
		av(8'hF4, 1'b1, 8'h40);
		xd(16'h127F, 1'b1, 8'h3C);
		`CHK(xd_hit_o, 1'b1)
		usb_engine_model_inst.tx(4'h3, 1'b1, 1'b0, 6'h3F, rd);
		`CHK(rd, 8'h3C)
		av(8'hF7, 1'b1, 8'h02);
		usb_engine_model_inst.pkt(1'b0, 4'h2, 5, 8'hA0);
		av(8'hF2, 1'b0, 8'h00);
		`CHK(rd, 8'h05)
		xd(16'h1244, 1'b0, 8'h00);
		`CHK({xd_hit_o, xd_readdata_o}, 9'h1A4)
		xd(16'h1280, 1'b0, 8'h00);
		`CHK({xd_hit_o, xd_readdata_o}, 9'h000)
		$display("window done");
		usb_engine_model_inst.pkt(1'b1, 4'h0, 8, 8'h10);
		for (int i = 0; i < 8; i++)
		begin
			av(8'hF5, 1'b1, 8'(i));
			av(8'hF6, 1'b0, 8'h00);
			`CHK(rd, 8'h10 + 8'(i))
		end
		$display("setup done");
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		av(8'hF3, 1'b0, 8'h00);
		`CHK(rd, 8'h00)
		$display("reset done");
		give_verdict();
	end
endmodule : usb_fifo_window_setup_access_bench
`default_nettype wire
